// >>> host_mcu.sv
// host microcontroller model: wake pin and 16-bit serial frames
`timescale 1ns/10ps
module host_mcu (
  input wire logic clock_in,
  input wire logic miso_in,
  input wire logic miso_oe_n_in,
  output logic wake_n_out,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // a released data line reads high, as with a pull-up
  wire logic miso_w = miso_oe_n_in ? 1'b1 : miso_in;
  initial begin
    wake_n_out = 1'b1;
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic wake(input logic v);
    @(posedge clock_in);
    wake_n_out <= v;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  // 320 ns clock, idle low outside frames; data sampled on the rise
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] resp);
    int i;
    resp = 16'h0000;
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    repeat (8) @(posedge clock_in);
    for (i = 15; i >= 0; i--) begin
      mosi_out <= cmd[i];
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b1;
      resp[i] = miso_w;
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (8) @(posedge clock_in);
    cs_n_out <= 1'b1;
    mosi_out <= ~cmd[0];
    repeat (8) @(posedge clock_in);
  endtask
endmodule // host_mcu

// >>> pcd_defines.svh
// shared offsets, field positions, reset values and timing counts
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH
`define CLK_HZ 25000000
`define ODR_UNIT_MS 100
`define ODR_UNIT_CYC (`ODR_UNIT_MS * (`CLK_HZ / 1000))
`define INT_PULSE_US 10
`define INT_PULSE_CYC (`INT_PULSE_US * (`CLK_HZ / 1000000))
`define HIST_DEPTH 12
`define PW 10
`define FLASH_AW 12
`define A_STATUS 13'h0000
`define A_CFG 13'h0001
`define A_CMD 13'h0002
`define A_ODR 13'h0003
`define A_FIXL 13'h0004
`define A_FIXH 13'h0005
`define A_DEB 13'h0006
`define A_MIN 13'h0007
`define A_RELL 13'h0008
`define A_RELH 13'h0009
`define A_SLPL 13'h000A
`define A_SLPH 13'h000B
`define A_STPER 13'h000C
`define A_SENS 13'h000D
`define A_RESULT 13'h000E
`define A_HIST 13'h0010
`define A_HIST_END 13'h0027
`define A_SAC 13'h0038
`define RW_MASK 16'h1FFA
`define SAC_RESET 8'h04
`define S_INTF 0
`define S_FIX 1
`define S_REL 2
`define S_SLP 3
`define S_DRDY 4
`define S_STF 5
`define S_CKF 6
`define C_FIX 0
`define C_REL 1
`define C_SLP 2
`define C_MEAS 3
`define C_SUP 4
`define C_STPER 5
`define C_STPUL 6
`define C_CKPUL 7
`define M_ACK 0
`define M_STEST 1
`define M_CKSUM 2
`define SS_PAR 0
`define SS_ADDR 1
`endif

// >>> pcd_detectors.sv
// fixed, relative and slope change detectors, one pass per sample
`timescale 1ns/10ps
`include "pcd_defines.svh"
module pcd_detectors (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sample_in,
  input wire logic [9:0] pressure_in,
  input wire logic [9:0] previous_in,
  input wire logic [7:0] cfg_in,
  input wire logic [9:0] fix_thr_in,
  input wire logic [7:0] deb_lim_in,
  input wire logic [7:0] min_inc_in,
  input wire logic [9:0] rel_thr_in,
  input wire logic [15:0] slope_thr_in,
  output logic [2:0] hit_out,
  output logic done_out
);
  logic [7:0] ft_r, ft_nxt, ic_r, ic_nxt, rt_r, rt_nxt, sc_r, sc_nxt;
  logic [9:0] rref_r, rref_nxt, sref_r, sref_nxt;
  logic [15:0] t_r, t_nxt;
  logic [2:0] hit_nxt;
  logic rising;
  logic [32:0] lhs, rhs;

  function automatic logic [7:0] step(input logic [7:0] c, input logic up);
    if (up) step = (c == 8'hFF) ? c : c + 8'h01;
    else step = (c == 8'h00) ? c : c - 8'h01;
  endfunction

  // drift below the minimum increment does not count as a rise
  assign rising = {1'b0, pressure_in} > ({1'b0, previous_in} + {3'b000, min_inc_in});
  assign lhs = {16'h0000, pressure_in - sref_r, 7'h00};
  assign rhs = slope_thr_in * ({1'b0, t_r} + 17'h00001);

  always_comb begin
    ft_nxt = ft_r;
    ic_nxt = ic_r;
    rt_nxt = rt_r;
    sc_nxt = sc_r;
    rref_nxt = rref_r;
    sref_nxt = sref_r;
    t_nxt = t_r;
    hit_nxt = 3'b000;
    if (sample_in) begin
      if (cfg_in[`C_FIX]) begin
        ft_nxt = step(ft_r, pressure_in > fix_thr_in);
        hit_nxt[0] = ft_nxt > deb_lim_in;
      end
      if (cfg_in[`C_REL]) begin
        ic_nxt = step(ic_r, rising);
        if (rising) rt_nxt = step(rt_r, (pressure_in > rref_r) &&
                                  ((pressure_in - rref_r) > rel_thr_in));
        hit_nxt[1] = rt_nxt > deb_lim_in;
        if (ic_nxt == 8'h00 && rt_nxt == 8'h00) rref_nxt = pressure_in;
      end
      if (cfg_in[`C_SLP]) begin
        sc_nxt = step(sc_r, rising);
        if (sc_nxt == 8'h00 || t_r == 16'hFFFF) begin
          // restart rather than let the elapsed time roll over
          sc_nxt = 8'h00;
          t_nxt = 16'h0000;
          sref_nxt = pressure_in;
        end else begin
          t_nxt = t_r + 16'h0001;
          hit_nxt[2] = (sc_nxt > deb_lim_in) && (pressure_in > sref_r) && (lhs > rhs);
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ft_r <= 8'h00;
      ic_r <= 8'h00;
      rt_r <= 8'h00;
      sc_r <= 8'h00;
      rref_r <= 10'h000;
      sref_r <= 10'h000;
      t_r <= 16'h0000;
      hit_out <= 3'b000;
      done_out <= 1'b0;
    end else begin
      ft_r <= ft_nxt;
      ic_r <= ic_nxt;
      rt_r <= rt_nxt;
      sc_r <= sc_nxt;
      rref_r <= rref_nxt;
      sref_r <= sref_nxt;
      t_r <= t_nxt;
      hit_out <= hit_nxt;
      done_out <= sample_in;
    end
  end
endmodule // pcd_detectors

// >>> pcd_notify_chk.sv
// assertion checker for the pressure change notify block
`timescale 1ns/10ps
module pcd_notify_chk #(
  parameter int ODR_UNIT_CYC = 20
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic loc_re_in,
  input wire logic [7:0] loc_rdata_out,
  input wire logic wake_n_in,
  input wire logic cs_n_in,
  input wire logic miso_oe_n_out,
  input wire logic int_out,
  input wire logic supply_enable_out,
  input wire logic run_out,
  input wire logic meas_req_out,
  input wire logic selftest_req_out
);
  // pulse length and sample spacing are too long to unroll, so count them
  logic [8:0] hi_r, hi_nxt;
  logic [31:0] gap_r, gap_nxt;
  always_comb begin
    hi_nxt = int_out ? hi_r + 9'h001 : 9'h000;
    gap_nxt = meas_req_out ? 32'h0000_0000 : gap_r + 32'h0000_0001;
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hi_r <= 9'h000;
      gap_r <= 32'h0000_0000;
    end else begin
      hi_r <= hi_nxt;
      gap_r <= gap_nxt;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_read_data_once: assert property (!$past(loc_re_in) |-> loc_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_int_max_len: assert property (hi_r <= 9'h0FA)
    else $error("interrupt pulse too long");
  a_int_exact_len: assert property ($fell(int_out) |-> hi_r == 9'h0FA)
    else $error("interrupt pulse length wrong");
  a_int_wakes_host: assert property ($rose(int_out) |-> run_out)
    else $error("pulse without serial enabled");
  a_supply_in_run: assert property (supply_enable_out |-> run_out)
    else $error("supply enable while asleep");
  a_wake_runs: assert property ($fell(wake_n_in) |-> ##[1:4] run_out)
    else $error("wake did not enable serial");
  a_cs_release: assert property ($rose(cs_n_in) |-> ##[1:6] miso_oe_n_out)
    else $error("data line held after frame");
  a_oe_in_run: assert property ($fell(miso_oe_n_out) |-> run_out)
    else $error("data line driven while asleep");
  a_sample_period: assert property (meas_req_out |-> gap_r >= ODR_UNIT_CYC - 2)
    else $error("samples too close");
  a_selftest_pulse: assert property (selftest_req_out |=> !selftest_req_out)
    else $error("self-test request too long");
  c_int: cover property ($rose(int_out));
  c_frame: cover property ($fell(miso_oe_n_out));
  c_selftest: cover property (selftest_req_out);
endmodule // pcd_notify_chk

bind pressure_change_detect_notify pcd_notify_chk #(.ODR_UNIT_CYC(ODR_UNIT_CYC)) chk (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .loc_re_in(loc_re_in),
  .loc_rdata_out(loc_rdata_out), .wake_n_in(wake_n_in), .cs_n_in(cs_n_in),
  .miso_oe_n_out(miso_oe_n_out), .int_out(int_out), .supply_enable_out(supply_enable_out),
  .run_out(run_out), .meas_req_out(meas_req_out), .selftest_req_out(selftest_req_out));

// >>> pcd_pkg.sv
// types shared by the pressure change detection block
package pcd_pkg;
  typedef enum logic [1:0] {
    st_sleep = 2'b00,
    st_serial = 2'b01,
    st_action = 2'b11
  } dev_state_t;
  typedef enum logic [1:0] {
    ck_idle = 2'b00,
    ck_run = 2'b01,
    ck_cmp = 2'b11
  } ck_state_t;
endpackage

// >>> pcd_serial_slave.sv
// serial slave: 16-bit frames, link pins sampled on the core clock
`timescale 1ns/10ps
module pcd_serial_slave (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic enable_in,
  input wire logic [15:0] resp_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  output logic frame_valid_out,
  output logic [15:0] frame_out,
  output logic busy_out
);
  logic [2:0] s1_r, s2_r;
  logic [1:0] s3_r;
  logic act_r, act_nxt, miso_nxt, fv_nxt;
  logic [15:0] in_r, in_nxt, out_r, out_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic rise, fall, cs_fall, cs_rise;

  // s1 feeds only s2; edges come from s2 against s3
  assign rise = s2_r[0] & ~s3_r[0];
  assign fall = ~s2_r[0] & s3_r[0];
  assign cs_fall = ~s2_r[1] & s3_r[1];
  assign cs_rise = s2_r[1] & ~s3_r[1];

  always_comb begin
    act_nxt = act_r;
    in_nxt = in_r;
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    miso_nxt = miso_out;
    fv_nxt = 1'b0;
    if (cs_fall && enable_in) begin
      act_nxt = 1'b1;
      out_nxt = resp_in;
      miso_nxt = resp_in[15];
      cnt_nxt = 5'h00;
    end else if (act_r && cs_rise) begin
      act_nxt = 1'b0;
      fv_nxt = (cnt_r == 5'h10);
    end else if (act_r && rise) begin
      in_nxt = {in_r[14:0], s2_r[2]};
      if (cnt_r != 5'h1F) cnt_nxt = cnt_r + 5'h01;
    end else if (act_r && fall) begin
      out_nxt = {out_r[14:0], 1'b0};
      miso_nxt = out_r[14];
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_r <= 3'h2;
      s2_r <= 3'h2;
      s3_r <= 2'h2;
      act_r <= 1'b0;
      in_r <= 16'h0000;
      out_r <= 16'h0000;
      cnt_r <= 5'h00;
      miso_out <= 1'b0;
      miso_oe_n_out <= 1'b1;
      frame_valid_out <= 1'b0;
      frame_out <= 16'h0000;
      busy_out <= 1'b0;
    end else begin
      s1_r <= {mosi_in, cs_n_in, sclk_in};
      s2_r <= s1_r;
      s3_r <= s2_r[1:0];
      act_r <= act_nxt;
      in_r <= in_nxt;
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
      miso_out <= miso_nxt;
      miso_oe_n_out <= ~act_nxt;
      frame_valid_out <= fv_nxt;
      if (fv_nxt) frame_out <= in_r;
      busy_out <= ~s2_r[1];
    end
  end
endmodule // pcd_serial_slave

// >>> pressure_change_detect_notify.sv
// top: periodic sampling, history, change detection and host notification
`timescale 1ns/10ps
`include "pcd_defines.svh"
// Behaviour
// - keep the last 12 pressure results, oldest dropped on each new one
// - sample at the selected rate and run enabled checks once per sample
// - wake low enables the serial port; stay running until transfers end
// - host reads and writes memory; requested actions run after transfers
// - on a pulse condition set flag, enable serial, opt supply, pulse pin
// - three detectors enabled independently; any one hit notifies
// - after the detectors run, any change flag sets the host event flag
// - fixed counter counts up above threshold, down otherwise
// - debounce counters stop at zero
// - fixed flag set when counter exceeds the debounce limit
// - relative flag when rise over reference exceeds relative threshold
// - slope flag when slope over the rising time exceeds its threshold
// - measurement notice on new data or acquisition error when enabled
// - self-test periodic or on command; result kept; optional pulse
// - command runs 16-bit xor checksum of flash against stored value
// - command frame: write flag, 13-bit address, two parity bits
// - response: flag, five status bits, data byte, parity; nonzero=error
// - rising only when sample beats previous by over the minimum step
module pressure_change_detect_notify #(
  parameter int ODR_UNIT_CYC = `ODR_UNIT_CYC
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] loc_addr_in,
  input wire logic [7:0] loc_wdata_in,
  input wire logic loc_we_in,
  input wire logic loc_re_in,
  output logic [7:0] loc_rdata_out,
  input wire logic wake_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  output logic int_out,
  output logic supply_enable_out,
  output logic run_out,
  output logic meas_req_out,
  input wire logic [9:0] pressure_in,
  input wire logic pressure_valid_in,
  input wire logic acq_error_in,
  output logic selftest_req_out,
  input wire logic selftest_done_in,
  input wire logic selftest_fail_in,
  output logic [11:0] flash_addr_out,
  input wire logic [15:0] flash_data_in,
  input wire logic [15:0] prod_checksum_in
);
  localparam logic [15:0] RW_MASK = `RW_MASK;
  localparam logic [7:0] INT_CYC = 8'(`INT_PULSE_CYC);

  pcd_pkg::dev_state_t st_r, st_nxt;
  pcd_pkg::ck_state_t ck_r, ck_nxt;
  logic [1:0] wk_r;
  logic wake_lo, busy, fr_v, det_done, sample_r;
  logic [15:0] fr, resp_r, resp_nxt, acc_r, acc_nxt;
  logic [2:0] hit;
  logic [7:0] rw_r [16];
  logic [7:0] rw_nxt [16];
  logic [9:0] hist_r [`HIST_DEPTH];
  logic [9:0] hist_nxt [`HIST_DEPTH];
  logic [7:0] cfg, stat_r, stat_nxt, sens_r, sens_nxt, res_r, res_nxt, sac_r, sac_nxt;
  logic [7:0] int_cnt_r, int_cnt_nxt, unit_r, unit_nxt, stc_r, stc_nxt, wd, rdv;
  logic [21:0] pre_r, pre_nxt;
  logic [12:0] wa, waddr_r, waddr_nxt;
  logic wpend_r, wpend_nxt, we, s_we, ev, par_ok, tick, ck_done, ck_fail;
  logic [12:0] s_wa;
  logic [7:0] s_wd, sdat;
  logic [4:0] sts;
  logic [8:0] rd;
  logic ackp_r, ackp_nxt, stp_r, stp_nxt, ckp_r, ckp_nxt, sup_nxt;
  logic mreq_nxt, streq_nxt, dv_r, dv_nxt;
  logic [11:0] fa_nxt;

  assign cfg = rw_r[1];
  assign wake_lo = ~wk_r[1];

  // register view shared by the local port and the serial link
  function automatic logic [8:0] rd_fn(input logic [12:0] a);
    logic [12:0] k;
    k = a - `A_HIST;
    rd_fn = 9'h000;
    if (a == `A_STATUS) rd_fn = {1'b1, stat_r};
    else if (a == `A_CMD) rd_fn = 9'h100;
    else if (a == `A_SENS) rd_fn = {1'b1, sens_r};
    else if (a == `A_RESULT) rd_fn = {1'b1, res_r};
    else if (a == `A_SAC) rd_fn = {1'b1, sac_r};
    else if (a < 13'h0010) rd_fn = {1'b1, rw_r[a[3:0]]};
    else if (a <= `A_HIST_END) begin
      if (k[0]) rd_fn = {1'b1, 6'h00, hist_r[k[4:1]][9:8]};
      else rd_fn = {1'b1, hist_r[k[4:1]][7:0]};
    end
  endfunction

  pcd_serial_slave u_slave (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .enable_in(run_out),
    .resp_in(resp_r),
    .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out),
    .frame_valid_out(fr_v),
    .frame_out(fr),
    .busy_out(busy)
  );

  pcd_detectors u_det (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .sample_in(sample_r),
    .pressure_in(hist_r[0]),
    .previous_in(hist_r[1]),
    .cfg_in(cfg),
    .fix_thr_in({rw_r[5][1:0], rw_r[4]}),
    .deb_lim_in(rw_r[6]),
    .min_inc_in(rw_r[7]),
    .rel_thr_in({rw_r[9][1:0], rw_r[8]}),
    .slope_thr_in({rw_r[11], rw_r[10]}),
    .hit_out(hit),
    .done_out(det_done)
  );

  // history: entry 0 is the newest
  generate
    for (genvar i = 0; i < `HIST_DEPTH; i++) begin : g_hist
      always_comb begin
        hist_nxt[i] = hist_r[i];
        if (pressure_valid_in) hist_nxt[i] = (i == 0) ? pressure_in : hist_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  // sample timing and periodic self-test
  assign tick = (pre_r == 22'(ODR_UNIT_CYC - 1)) && (unit_r == rw_r[3]);
  always_comb begin
    pre_nxt = pre_r + 22'h00_0001;
    unit_nxt = unit_r;
    stc_nxt = stc_r;
    mreq_nxt = tick;
    streq_nxt = (st_r == pcd_pkg::st_action) && stp_r;
    if (pre_r == 22'(ODR_UNIT_CYC - 1)) begin
      pre_nxt = 22'h00_0000;
      unit_nxt = tick ? 8'h00 : unit_r + 8'h01;
    end
    if (tick && cfg[`C_STPER]) begin
      stc_nxt = stc_r + 8'h01;
      if (stc_r >= rw_r[12]) begin
        stc_nxt = 8'h00;
        streq_nxt = 1'b1;
      end
    end
  end

  // flash checksum engine, one word per cycle with one cycle read latency
  assign ck_done = (ck_r == pcd_pkg::ck_cmp);
  assign ck_fail = (acc_r ^ flash_data_in) != prod_checksum_in;
  always_comb begin
    ck_nxt = ck_r;
    acc_nxt = acc_r;
    fa_nxt = flash_addr_out;
    dv_nxt = 1'b0;
    if (dv_r) acc_nxt = acc_r ^ flash_data_in;
    unique case (ck_r)
      pcd_pkg::ck_idle: begin
        if ((st_r == pcd_pkg::st_action) && ckp_r) begin
          ck_nxt = pcd_pkg::ck_run;
          acc_nxt = 16'h0000;
          fa_nxt = 12'h000;
        end
      end
      pcd_pkg::ck_run: begin
        dv_nxt = 1'b1;
        if (flash_addr_out == 12'hFFF) ck_nxt = pcd_pkg::ck_cmp;
        else fa_nxt = flash_addr_out + 12'h001;
      end
      pcd_pkg::ck_cmp: ck_nxt = pcd_pkg::ck_idle;
    endcase
  end

  // serial decode, register writes, events and run state
  always_comb begin
    rw_nxt = rw_r;
    sac_nxt = sac_r;
    stat_nxt = stat_r;
    sens_nxt = sens_r;
    res_nxt = res_r;
    st_nxt = st_r;
    resp_nxt = resp_r;
    wpend_nxt = wpend_r;
    waddr_nxt = waddr_r;
    ackp_nxt = ackp_r;
    stp_nxt = stp_r;
    ckp_nxt = ckp_r;
    sup_nxt = supply_enable_out;
    int_cnt_nxt = (int_cnt_r == 8'h00) ? 8'h00 : int_cnt_r - 8'h01;
    s_we = 1'b0;
    s_wa = 13'h0000;
    s_wd = 8'h00;
    sts = 5'h00;
    sdat = 8'h00;
    ev = 1'b0;
    par_ok = (fr[1] == ^fr[15:8]) && (fr[0] == ^fr[7:2]);
    rd = rd_fn(fr[14:2]);
    if (fr_v) begin
      if (!par_ok) begin
        sts[`SS_PAR] = 1'b1;
        wpend_nxt = 1'b0;
      end else if (fr[15] && !wpend_r) begin
        wpend_nxt = 1'b1;
        waddr_nxt = fr[14:2];
      end else if (fr[15]) begin
        // second write frame carries the data byte in its address field
        wpend_nxt = 1'b0;
        s_we = 1'b1;
        s_wa = waddr_r;
        s_wd = fr[9:2];
      end else if (!rd[8]) begin
        sts[`SS_ADDR] = 1'b1;
      end else begin
        sdat = rd[7:0];
      end
      resp_nxt = {fr[15], sts, sdat, ^{fr[15], sts, sdat[7:6]}, ^sdat[5:0]};
    end
    // clears come first so a command written in the action cycle is kept
    if (st_r == pcd_pkg::st_action) begin
      if (ackp_r) stat_nxt = 8'h00;
      ackp_nxt = 1'b0;
      stp_nxt = 1'b0;
      ckp_nxt = 1'b0;
    end
    we = loc_we_in | s_we;
    wa = loc_we_in ? {5'h00, loc_addr_in} : s_wa;
    wd = loc_we_in ? loc_wdata_in : s_wd;
    if (we) begin
      if (wa < 13'h0010 && RW_MASK[wa[3:0]]) rw_nxt[wa[3:0]] = wd;
      if (wa == `A_SAC) sac_nxt = wd;
      if (wa == `A_CMD) begin
        ackp_nxt = ackp_r | wd[`M_ACK];
        stp_nxt = stp_r | wd[`M_STEST];
        ckp_nxt = ckp_r | wd[`M_CKSUM];
      end
    end
    // sets below override the acknowledge clear in the same cycle
    if (pressure_valid_in) sens_nxt = {6'h00, 1'b1, acq_error_in};
    if (det_done) begin
      if (hit[0]) stat_nxt[`S_FIX] = 1'b1;
      if (hit[1]) stat_nxt[`S_REL] = 1'b1;
      if (hit[2]) stat_nxt[`S_SLP] = 1'b1;
      if (cfg[`C_MEAS]) begin
        stat_nxt[`S_DRDY] = 1'b1;
        ev = 1'b1;
      end
      if (|stat_nxt[`S_SLP:`S_FIX]) ev = 1'b1;
    end
    if (selftest_done_in) begin
      res_nxt[0] = selftest_fail_in;
      if (selftest_fail_in) stat_nxt[`S_STF] = 1'b1;
      if (selftest_fail_in && cfg[`C_STPUL]) ev = 1'b1;
    end
    if (ck_done) begin
      res_nxt[1] = ck_fail;
      if (ck_fail) stat_nxt[`S_CKF] = 1'b1;
      if (ck_fail && cfg[`C_CKPUL]) ev = 1'b1;
    end
    if (ev) begin
      stat_nxt[`S_INTF] = 1'b1;
      int_cnt_nxt = INT_CYC;
      sup_nxt = supply_enable_out | cfg[`C_SUP];
    end
    unique case (st_r)
      pcd_pkg::st_sleep: begin
        if (wake_lo || ev || ackp_r || stp_r || ckp_r) st_nxt = pcd_pkg::st_serial;
      end
      pcd_pkg::st_serial: begin
        if (!wake_lo && !busy && !wpend_r && !fr_v) begin
          if (ackp_r || stp_r || ckp_r) st_nxt = pcd_pkg::st_action;
          else if (!stat_r[`S_INTF] && !ev) st_nxt = pcd_pkg::st_sleep;
        end
      end
      pcd_pkg::st_action: st_nxt = pcd_pkg::st_serial;
    endcase
    if (st_nxt == pcd_pkg::st_sleep) sup_nxt = 1'b0;
    rdv = loc_re_in ? 8'(rd_fn({5'h00, loc_addr_in})) : 8'h00;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wk_r <= 2'b11;
      st_r <= pcd_pkg::st_sleep;
      ck_r <= pcd_pkg::ck_idle;
      for (int i = 0; i < 16; i++) rw_r[i] <= 8'h00;
      for (int i = 0; i < `HIST_DEPTH; i++) hist_r[i] <= 10'h000;
      stat_r <= 8'h00;
      sens_r <= 8'h00;
      res_r <= 8'h00;
      sac_r <= `SAC_RESET;
      resp_r <= 16'h0000;
      wpend_r <= 1'b0;
      waddr_r <= 13'h0000;
      ackp_r <= 1'b0;
      stp_r <= 1'b0;
      ckp_r <= 1'b0;
      int_cnt_r <= 8'h00;
      pre_r <= 22'h00_0000;
      unit_r <= 8'h00;
      stc_r <= 8'h00;
      acc_r <= 16'h0000;
      dv_r <= 1'b0;
      sample_r <= 1'b0;
      loc_rdata_out <= 8'h00;
      int_out <= 1'b0;
      supply_enable_out <= 1'b0;
      run_out <= 1'b0;
      meas_req_out <= 1'b0;
      selftest_req_out <= 1'b0;
      flash_addr_out <= 12'h000;
    end else begin
      wk_r <= {wk_r[0], wake_n_in};
      st_r <= st_nxt;
      ck_r <= ck_nxt;
      rw_r <= rw_nxt;
      hist_r <= hist_nxt;
      stat_r <= stat_nxt;
      sens_r <= sens_nxt;
      res_r <= res_nxt;
      sac_r <= sac_nxt;
      resp_r <= resp_nxt;
      wpend_r <= wpend_nxt;
      waddr_r <= waddr_nxt;
      ackp_r <= ackp_nxt;
      stp_r <= stp_nxt;
      ckp_r <= ckp_nxt;
      int_cnt_r <= int_cnt_nxt;
      pre_r <= pre_nxt;
      unit_r <= unit_nxt;
      stc_r <= stc_nxt;
      acc_r <= acc_nxt;
      dv_r <= dv_nxt;
      sample_r <= pressure_valid_in;
      loc_rdata_out <= rdv;
      int_out <= int_cnt_nxt != 8'h00;
      supply_enable_out <= sup_nxt;
      run_out <= st_nxt != pcd_pkg::st_sleep;
      meas_req_out <= mreq_nxt;
      selftest_req_out <= streq_nxt;
      flash_addr_out <= fa_nxt;
    end
  end
endmodule // pressure_change_detect_notify

// >>> tb.sv
// self-checking bench: local port, host frames and change events
`timescale 1ns/10ps
module tb;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [9:0] pres = 10'h000;
  logic pvalid = 1'b0;
  logic st_done = 1'b0;
  logic st_fail = 1'b0;
  logic aerr = 1'b0;
  logic [7:0] rdata;
  logic wake_n, sclk, cs_n, mosi, miso, miso_oe_n, int_o, sup, run, meas, st_req;
  int failures = 0;
  int n_checks = 0;
  always #20 clock_in = ~clock_in;
  host_mcu host (.clock_in(clock_in), .miso_in(miso), .miso_oe_n_in(miso_oe_n),
    .wake_n_out(wake_n), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
  pressure_change_detect_notify #(.ODR_UNIT_CYC(20)) dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .loc_addr_in(addr),
    .loc_wdata_in(wdata), .loc_we_in(we), .loc_re_in(re), .loc_rdata_out(rdata),
    .wake_n_in(wake_n), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_n_out(miso_oe_n), .int_out(int_o),
    .supply_enable_out(sup), .run_out(run), .meas_req_out(meas),
    .pressure_in(pres), .pressure_valid_in(pvalid), .acq_error_in(aerr),
    .selftest_req_out(st_req), .selftest_done_in(st_done), .selftest_fail_in(st_fail),
    .flash_addr_out(), .flash_data_in(16'h0000), .prod_checksum_in(16'h0000));
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic [15:0] frm(input logic [13:0] hi);
    logic [15:0] f;
    f = {hi, 2'b00};
    f[1] = ^f[15:8];
    f[0] = ^f[7:2];
    return f;
  endfunction
  task automatic lw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock_in);
    we <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp,
      input logic [7:0] mask);
    @(posedge clock_in);
    addr <= a;
    re <= 1'b1;
    @(posedge clock_in);
    re <= 1'b0;
    @(negedge clock_in);
    cmp(what, {8'h00, exp}, {8'h00, rdata & mask});
  endtask
  // a sample is offered when the block asks for one, or after 100 cycles without a request
  task automatic feed(input logic [9:0] p);
    int k;
    for (k = 0; k < 100 && meas !== 1'b1; k++) @(negedge clock_in);
    cmp_bit("sample request", 1'b1, meas);
    @(posedge clock_in);
    pres <= p;
    pvalid <= 1'b1;
    @(posedge clock_in);
    pvalid <= 1'b0;
    repeat (6) @(negedge clock_in);
  endtask
  task automatic settle;
    int k;
    for (k = 0; k < 400 && int_o === 1'b1; k++) @(negedge clock_in);
    cmp_bit("pulse end", 1'b0, int_o);
    rd("cause", 8'h00, 8'h01, 8'h01);
    lw(8'h01, 8'h00);
    lw(8'h02, 8'h01);
    @(negedge clock_in);
    for (k = 0; k < 40 && run !== 1'b0; k++) @(negedge clock_in);
    cmp_bit("asleep", 1'b0, run);
    cmp_bit("supply off", 1'b0, sup);
    rd("flags", 8'h00, 8'h00, 8'h0F);
  endtask
  task automatic t_reset;
    cmp_bit("int idle", 1'b0, int_o);
    cmp_bit("data line off", 1'b1, miso_oe_n);
    rd("access ctrl", 8'h38, 8'h04, 8'hFF);
    rd("status", 8'h00, 8'h00, 8'hFF);
    rd("unmapped", 8'h28, 8'h00, 8'hFF);
    $display("test reset done");
  endtask
  // two low samples first: a counter that wraps below zero flags at once
  task automatic t_fixed;
    lw(8'h03, 8'h00);
    lw(8'h04, 8'h64);
    lw(8'h05, 8'h00);
    lw(8'h06, 8'h02);
    lw(8'h01, 8'h11);
    feed(10'h032);
    feed(10'h032);
    feed(10'h0C8);
    feed(10'h0C8);
    rd("no flag yet", 8'h00, 8'h00, 8'h0F);
    cmp_bit("no pulse", 1'b0, int_o);
    feed(10'h0C8);
    cmp_bit("pulse", 1'b1, int_o);
    cmp_bit("supply on", 1'b1, sup);
    rd("fixed flag", 8'h00, 8'h03, 8'h0F);
    rd("newest", 8'h10, 8'hC8, 8'hFF);
    rd("fourth", 8'h16, 8'h32, 8'hFF);
    settle();
    $display("test fixed done");
  endtask
  task automatic t_notice;
    int k;
    lw(8'h01, 8'h08);
    aerr <= 1'b1;
    feed(10'h005);
    cmp_bit("data pulse", 1'b1, int_o);
    rd("sensor", 8'h0D, 8'h03, 8'hFF);
    settle();
    lw(8'h01, 8'h40);
    lw(8'h02, 8'h02);
    for (k = 0; k < 60 && st_req !== 1'b1; k++) @(negedge clock_in);
    cmp_bit("self-test start", 1'b1, st_req);
    @(posedge clock_in);
    st_done <= 1'b1;
    st_fail <= 1'b1;
    @(posedge clock_in);
    st_done <= 1'b0;
    st_fail <= 1'b0;
    repeat (6) @(negedge clock_in);
    cmp_bit("fail pulse", 1'b1, int_o);
    rd("self-test result", 8'h0E, 8'h01, 8'h01);
    settle();
    $display("test notice done");
  endtask
  task automatic t_serial;
    logic [15:0] r;
    host.wake(1'b0);
    cmp_bit("running", 1'b1, run);
    host.xfer(frm({1'b1, 13'h0038}), r);
    host.xfer(frm({1'b1, 13'h0007}), r);
    host.xfer(frm({1'b0, 13'h0038}), r);
    host.xfer(16'h00E0, r);
    cmp("read reply", frm({1'b0, 5'h00, 8'h07}), r);
    host.xfer(frm({1'b0, 13'h0038}), r);
    cmp_bit("parity status", 1'b1, r[10]);
    host.wake(1'b1);
    rd("access ctrl", 8'h38, 8'h07, 8'hFF);
    $display("test serial done");
  endtask
  initial begin
    #800000;
    failures++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(negedge clock_in);
    t_reset();
    t_fixed();
    t_notice();
    t_serial();
    close_out();
  end
endmodule // tb
